// ===== bench/dsi_link_src.sv
`timescale 1ns/10ps
// ****************************************************************
// sample source: ddr link, clock idles low between pairs
// ****************************************************************
module dsi_link_src
    import dsi_pkg::*;
(
    // link pins
    output logic                         linkClock,
    output logic [dsi_pkg::SAMPLE_W-1:0] linkBus
);
    import dsi_pkg::*;
    initial
    begin
        linkClock = 1'b0;
        linkBus = '0;
    end
    // word set up 40 ns before each edge, 80 ns half periods
    task automatic sendPair(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
        linkBus <= a;
        #40 linkClock <= 1'b1;
        #40 linkBus <= b;
        #40 linkClock <= 1'b0;
        #20 linkBus <= ~b; // held time over: stale word must not be reused
        #20;
    endtask
endmodule

// ===== bench/dual_dac_ddr_sample_input_test.sv
`timescale 1ns/10ps
module dual_dac_ddr_sample_input_test;
    import dsi_pkg::*;
    // ****************************************************************
    // stimulus, model and checks
    // ****************************************************************
    logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdVal;
    logic pready, pslverr, errFlag, lClk, ioOut, ioOe, sdOut, sdOe, strobe, slp, alarm, irq;
    logic [SAMPLE_W-1:0] sBus;
    logic gate = 0, sleep = 0, syncIn = 0, sRst_n = 1, sClk = 0, sSel_n = 1, sDin = 0;
    dsi_pair_s corePair;
    logic [31:0] seed = 32'ha729, r32;
    logic [23:0] pairQ[$];
    logic [7:0] sRd;
    logic [1:0] sOe;
    int errors = 0, compares = 0;
    always #10 clock = ~clock;
    dsi_link_src src_u (.linkClock(lClk), .linkBus(sBus));
    dsi_sample_input dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .inputSampleClock(lClk), .sampleBus(sBus), .transmitGate(gate),
        .sleep(sleep), .fifoSyncIn(syncIn), .serialReset_n(sRst_n), .serialClock(sClk),
        .serialSelect_n(sSel_n), .serialDataIoIn(sDin), .serialDataIoOut(ioOut),
        .serialDataIoOe(ioOe), .serialDataOut(sdOut), .serialDataOutOe(sdOe),
        .corePair(corePair), .coreStrobe(strobe), .sleepActive(slp), .alarm(alarm), .irq(irq));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // only the watchdog ends a hung wait
        do @(posedge clock); while (pready !== 1'b1);
        rdVal = prdata;
        errFlag = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ser(input logic [15:0] f, input logic fromOut,
                       output logic [7:0] rd, output logic [1:0] oe);
        rd = '0;
        oe = '0;
        sSel_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            repeat (6) @(posedge clock);
            sDin <= f[i];
            sClk <= 1'b0;
            repeat (6) @(posedge clock);
            sClk <= 1'b1;
            // read bits taken at host rising edges; any drive seen is kept
            if (i < 8)
            begin
                rd[i] = fromOut ? sdOut : ioOut;
                oe = oe | {sdOe, ioOe};
            end
        end
        repeat (6) @(posedge clock);
        sSel_n <= 1'b1;
        sClk <= 1'b0;
        repeat (6) @(posedge clock);
    endtask
    // nonzero words only: zero pairs come from empty reads
    always @(posedge clock)
        if (strobe === 1'b1 && corePair !== '0)
            chk({8'h00, corePair}, {8'h00, pairQ.pop_front()}, "sample pair");
    task automatic conclude();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        conclude();
    end
    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        apb(0, OFS_CTRL, 0);
        chk(rdVal, CTRL_RESET, "ctrl reset");
        apb(0, 8'h40, 0);
        chk(errFlag, 1, "unmapped");
        chk({ioOe, sdOe}, 0, "serial pins idle");
        gate <= 1'b1;
        repeat (6) @(posedge clock);
        repeat (6)
        begin
            r32 = xs();
            pairQ.push_back({r32[27:16], r32[11:0] | 12'h001});
            src_u.sendPair(r32[11:0] | 12'h001, r32[27:16]);
        end
        repeat (40) @(posedge clock);
        chk(pairQ.size(), 0, "pairs lost");
        $display("test stream done");
        gate <= 1'b0;
        repeat (6) @(posedge clock);
        chk(corePair, 0, "gate low");
        src_u.sendPair(12'h5a5, 12'h3c3);
        gate <= 1'b1;
        sleep <= 1'b1;
        repeat (8) @(posedge clock);
        chk({slp, corePair}, 32'h1000000, "sleep");
        src_u.sendPair(12'h111, 12'h222);
        sleep <= 1'b0;
        apb(1, OFS_CTRL, 32'h1);
        apb(1, OFS_INT_ENABLE, 32'h1 << EV_SYNC);
        syncIn <= 1'b1;
        src_u.sendPair(12'h000, 12'h000);
        syncIn <= 1'b0;
        repeat (10) @(posedge clock);
        chk({irq, alarm}, 2'b11, "sync event");
        apb(1, OFS_INT_ENABLE, 0);
        repeat (3) @(posedge clock);
        chk(irq, 0, "masked");
        apb(1, OFS_INT_CLEAR, 32'hffff_ffff);
        apb(0, OFS_INT_STATUS, 0);
        chk(rdVal[EV_SYNC], 0, "cleared");
        $display("test sync done");
        ser({1'b0, SER_CFG_ADDR, 8'h02}, 1'b0, sRd, sOe);
        chk(sOe, 0, "write frame drove");
        ser({1'b1, SER_CFG_ADDR, 8'h00}, 1'b0, sRd, sOe);
        chk({sOe, sRd}, {2'b01, 8'h02}, "3-wire read");
        // bit-reversed words under bus reversal
        pairQ.push_back({12'hc30, 12'h800});
        src_u.sendPair(12'h001, 12'h0c3);
        repeat (40) @(posedge clock);
        chk(pairQ.size(), 0, "reversed pair");
        ser({1'b0, SER_CFG_ADDR, 8'h01}, 1'b0, sRd, sOe);
        repeat (6) @(posedge clock);
        apb(0, OFS_STATE, 0);
        chk({rdVal[ST_FOUR_BIT], ioOe}, 2'b10, "four wire");
        ser({1'b1, SER_CFG_ADDR, 8'h00}, 1'b1, sRd, sOe);
        chk({sOe, sRd}, {2'b10, 8'h01}, "4-wire read");
        sRst_n <= 1'b0;
        repeat (2) @(posedge clock);
        sRst_n <= 1'b1;
        apb(0, OFS_STATE, 0);
        chk(rdVal[ST_FOUR_BIT], 0, "serial reset");
        $display("test serial done");
        conclude();
    end
endmodule

// ===== core/dsi_pkg.sv
package dsi_pkg;

    // ****************************************************************
    // widths and timing
    // ****************************************************************
    localparam int unsigned SAMPLE_W      = 12;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned RD_PERIOD_NS  = 160;
    localparam int unsigned RD_DIV_CYC    = (RD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FIFO_DEPTH    = 8;

    // ****************************************************************
    // apb register map
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_STATE      = 8'h04;
    localparam logic [7:0] OFS_INT_STATUS = 8'h08;
    localparam logic [7:0] OFS_INT_CLEAR  = 8'h0c;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h10;
    localparam logic [7:0] OFS_SAMPLE     = 8'h14;

    localparam int unsigned CTRL_SYNC_EN_BIT = 0;
    localparam int unsigned CTRL_RDOFS_LSB   = 4;
    localparam int unsigned CTRL_RDOFS_W     = 3;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0041;

    localparam int unsigned ST_GATE_BIT  = 0;
    localparam int unsigned ST_SLEEP_BIT = 1;
    localparam int unsigned ST_FOUR_BIT  = 2;
    localparam int unsigned ST_REV_BIT   = 3;
    localparam int unsigned ST_WPTR_LSB  = 8;
    localparam int unsigned ST_RPTR_LSB  = 16;
    localparam int unsigned SMP_CHB_LSB  = 16;

    localparam int unsigned EV_COLLIDE = 0;
    localparam int unsigned EV_SYNC    = 1;
    localparam int unsigned EV_SERWR   = 2;
    localparam int unsigned EV_W       = 3;
    localparam logic [EV_W-1:0] INT_RESET = 3'h0;

    // ****************************************************************
    // serial control port
    // ****************************************************************
    localparam int unsigned SER_FRAME_BITS = 16;
    localparam int unsigned SER_HDR_BITS   = 8;
    localparam logic [6:0]  SER_CFG_ADDR   = 7'h00;
    localparam int unsigned CFG_FOUR_BIT   = 0;
    localparam int unsigned CFG_REV_BIT    = 1;

    typedef struct packed {
        logic reverseBus;
        logic fourWire;
    } dsi_cfg_s;

    localparam dsi_cfg_s CFG_RESET = '{reverseBus: 1'b0, fourWire: 1'b0};

    typedef struct packed {
        logic [SAMPLE_W-1:0] chB;
        logic [SAMPLE_W-1:0] chA;
    } dsi_pair_s;

    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_SHIFT = 2'b01,
        SER_DRIVE = 2'b11,
        SER_DONE  = 2'b10
    } dsi_ser_e;

endpackage

// ===== core/dsi_sample_input.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps

// ****************************************************************
// three-stage pin synchroniser with agreement filter
// ****************************************************************
module dsi_pin_sync #(
    parameter int unsigned      WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // pins and filtered level
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] level_ff;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff    <= RST_VAL;
            s2_ff    <= RST_VAL;
            s3_ff    <= RST_VAL;
            level_ff <= RST_VAL;
        end
        else
        begin
            s1_ff    <= pinIn;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            // a bit moves only once stages two and three agree
            level_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (level_ff & (s2_ff ^ s3_ff));
        end
    end

    assign level = level_ff;
endmodule

module dsi_sample_input
    import dsi_pkg::*;
#(
    parameter int unsigned DATA_W     = dsi_pkg::SAMPLE_W,
    parameter int unsigned FIFO_DEPTH = dsi_pkg::FIFO_DEPTH,
    parameter int unsigned RD_DIV     = dsi_pkg::RD_DIV_CYC
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // sample link
    input  wire logic              inputSampleClock,
    input  wire logic [DATA_W-1:0] sampleBus,
    input  wire logic              transmitGate,
    input  wire logic              sleep,
    input  wire logic              fifoSyncIn,
    // serial control port
    input  wire logic              serialReset_n,
    input  wire logic              serialClock,
    input  wire logic              serialSelect_n,
    input  wire logic              serialDataIoIn,
    output logic                   serialDataIoOut,
    output logic                   serialDataIoOe,
    output logic                   serialDataOut,
    output logic                   serialDataOutOe,
    // converter core side
    output dsi_pkg::dsi_pair_s     corePair,
    output logic                   coreStrobe,
    output logic                   sleepActive,
    output logic                   alarm,
    output logic                   irq
);
    import dsi_pkg::*;

    localparam int unsigned PTR_W  = $clog2(FIFO_DEPTH);
    localparam int unsigned LINK_W = DATA_W + 4;
    localparam int unsigned DIV_W  = $clog2(RD_DIV + 1);

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [LINK_W-1:0] linkLvl;
    logic [2:0]        serLvl;

    dsi_pin_sync #(.WIDTH(LINK_W)) u_link_sync (
        .clock (clock),
        .rst_n (rst_n),
        .pinIn ({fifoSyncIn, sleep, transmitGate, sampleBus, inputSampleClock}),
        .level (linkLvl)
    );

    // select idles high: a zero reset level would open a false frame
    dsi_pin_sync #(.WIDTH(3), .RST_VAL(3'b010)) u_ser_sync (
        .clock (clock),
        .rst_n (rst_n),
        .pinIn ({serialDataIoIn, serialSelect_n, serialClock}),
        .level (serLvl)
    );

    logic              linkClk;
    logic [DATA_W-1:0] busData;
    logic              gateLvl;
    logic              sleepLvl;
    logic              syncLvl;
    logic              sclkLvl;
    logic              selLvl_n;
    logic              sdiLvl;

    assign linkClk  = linkLvl[0];
    assign busData  = linkLvl[DATA_W:1];
    assign gateLvl  = linkLvl[DATA_W+1];
    assign sleepLvl = linkLvl[DATA_W+2];
    assign syncLvl  = linkLvl[DATA_W+3];
    assign sclkLvl  = serLvl[0];
    assign selLvl_n = serLvl[1];
    assign sdiLvl   = serLvl[2];

    // ****************************************************************
    // configuration (serial reset clears it without the clock)
    // ****************************************************************
    dsi_cfg_s cfg_ff;
    logic     cfgRst_n;
    logic     cfgWrite;
    logic [7:0] cfgWdata;

    assign cfgRst_n = rst_n & serialReset_n;

    always_ff @(posedge clock or negedge cfgRst_n)
    begin
        if (!cfgRst_n)
            cfg_ff <= CFG_RESET;
        else if (cfgWrite)
        begin
            cfg_ff.fourWire   <= cfgWdata[CFG_FOUR_BIT];
            cfg_ff.reverseBus <= cfgWdata[CFG_REV_BIT];
        end
    end

    // ****************************************************************
    // ddr capture
    // ****************************************************************
    logic              linkClkPrev_ff;
    logic              linkRise;
    logic              linkFall;
    logic              gateOk;
    logic [DATA_W-1:0] busWord;
    logic [DATA_W-1:0] chALatch_ff;
    logic              haveA_ff;
    logic [31:0]       ctrl_ff;
    logic              syncHit;
    logic [PTR_W-1:0]  syncOfs;

    assign linkRise = linkClk & ~linkClkPrev_ff;
    assign linkFall = ~linkClk & linkClkPrev_ff;
    assign gateOk   = gateLvl & ~sleepLvl;
    assign syncOfs  = ctrl_ff[CTRL_RDOFS_LSB +: PTR_W];
    assign syncHit  = linkRise & syncLvl & ctrl_ff[CTRL_SYNC_EN_BIT];

    always_comb
    begin
        busWord = busData;
        if (cfg_ff.reverseBus)
            for (int i = 0; i < DATA_W; i++)
                busWord[i] = busData[DATA_W-1-i];
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            linkClkPrev_ff <= 1'b0;
        else
            linkClkPrev_ff <= linkClk;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chALatch_ff <= '0;
            haveA_ff    <= 1'b0;
        end
        else if (!gateOk)
            haveA_ff <= 1'b0;
        else if (linkRise)
        begin
            chALatch_ff <= busWord;
            haveA_ff    <= 1'b1;
        end
        else if (linkFall)
            haveA_ff <= 1'b0;
    end

    // ****************************************************************
    // input fifo, flip-flop storage
    // ****************************************************************
    dsi_pair_s        mem_ff [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr_ff;
    logic [PTR_W-1:0] rdPtr_ff;
    logic             pairWrite;
    dsi_pair_s        newPair;

    assign pairWrite = linkFall & gateOk & haveA_ff & ~syncHit;

    always_comb
    begin
        newPair     = '0;
        newPair.chA = SAMPLE_W'(chALatch_ff);
        newPair.chB = SAMPLE_W'(busWord);
    end

    always_ff @(posedge clock)
    begin
        if (pairWrite)
            mem_ff[wrPtr_ff] <= newPair;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wrPtr_ff <= '0;
        else if (syncHit)
            wrPtr_ff <= '0;
        else if (pairWrite)
            wrPtr_ff <= wrPtr_ff + 1'b1;
    end

    // read side runs at the core rate from a divider
    logic [DIV_W-1:0] divCnt_ff;
    logic             rdTick_ff;
    logic             collide;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divCnt_ff <= '0;
            rdTick_ff <= 1'b0;
        end
        else if (divCnt_ff == DIV_W'(RD_DIV - 1))
        begin
            divCnt_ff <= '0;
            rdTick_ff <= 1'b1;
        end
        else
        begin
            divCnt_ff <= divCnt_ff + 1'b1;
            rdTick_ff <= 1'b0;
        end
    end

    assign collide = rdTick_ff & gateOk & (rdPtr_ff == wrPtr_ff) & ~syncHit;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rdPtr_ff <= '0;
        else if (syncHit)
            rdPtr_ff <= syncOfs;
        else if (rdTick_ff && gateOk && !collide)
            rdPtr_ff <= rdPtr_ff + 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            corePair   <= '0;
            coreStrobe <= 1'b0;
        end
        else if (!gateOk)
        begin
            corePair   <= '0;
            coreStrobe <= 1'b0;
        end
        else
        begin
            // an empty fifo plays zeros rather than stale data unless a sync hit lands on the read tick
            if (rdTick_ff)
                corePair <= collide ? '0 : mem_ff[rdPtr_ff];
            coreStrobe <= rdTick_ff;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sleepActive <= 1'b0;
        else
            sleepActive <= sleepLvl;
    end

    // ****************************************************************
    // serial control port
    // ****************************************************************
    dsi_ser_e  serState_ff;
    logic [4:0]  bitCnt_ff;
    logic [15:0] shift_ff;
    logic [7:0]  rdShift_ff;
    logic        sclkPrev_ff;
    logic        sRise;
    logic        sFall;
    logic        isRead;

    assign sRise    = sclkLvl & ~sclkPrev_ff;
    assign sFall    = ~sclkLvl & sclkPrev_ff;
    assign isRead   = shift_ff[SER_HDR_BITS-2];
    assign cfgWrite = (serState_ff == SER_SHIFT) & sRise & ~shift_ff[SER_FRAME_BITS-2]
                      & (bitCnt_ff == 5'(SER_FRAME_BITS - 1))
                      & (shift_ff[SER_FRAME_BITS-3 -: 7] == SER_CFG_ADDR);
    assign cfgWdata = {shift_ff[6:0], sdiLvl};

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclkPrev_ff <= 1'b0;
            serState_ff <= SER_IDLE;
            bitCnt_ff   <= '0;
            shift_ff    <= '0;
            rdShift_ff  <= '0;
        end
        else
        begin
            sclkPrev_ff <= sclkLvl;
            if (selLvl_n)
                serState_ff <= SER_IDLE;
            else
            begin
                unique case (serState_ff)
                    SER_IDLE:
                    begin
                        bitCnt_ff   <= '0;
                        serState_ff <= SER_SHIFT;
                    end
                    SER_SHIFT:
                        if (sRise)
                        begin
                            shift_ff  <= {shift_ff[14:0], sdiLvl};
                            bitCnt_ff <= bitCnt_ff + 1'b1;
                            if (bitCnt_ff == 5'(SER_HDR_BITS - 1) && isRead)
                            begin
                                serState_ff <= SER_DRIVE;
                                rdShift_ff  <= (shift_ff[5:0] == SER_CFG_ADDR[6:1]
                                               && sdiLvl == SER_CFG_ADDR[0])
                                               ? {6'h00, cfg_ff} : 8'h00;
                            end
                            else if (bitCnt_ff == 5'(SER_FRAME_BITS - 1))
                                serState_ff <= SER_DONE;
                        end
                    SER_DRIVE:
                    begin
                        if (sFall)
                            rdShift_ff <= {rdShift_ff[6:0], 1'b0};
                        if (sRise)
                        begin
                            bitCnt_ff <= bitCnt_ff + 1'b1;
                            if (bitCnt_ff == 5'(SER_FRAME_BITS - 1))
                                serState_ff <= SER_DONE;
                        end
                    end
                    SER_DONE:
                        serState_ff <= SER_DONE;
                endcase
            end
        end
    end

    // read bit goes out on each falling serial clock edge
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serialDataIoOut <= 1'b0;
            serialDataIoOe  <= 1'b0;
            serialDataOut   <= 1'b0;
            serialDataOutOe <= 1'b0;
        end
        else
        begin
            if (sFall)
            begin
                serialDataIoOut <= rdShift_ff[7];
                serialDataOut   <= rdShift_ff[7];
            end
            serialDataIoOe  <= (serState_ff == SER_DRIVE) & ~selLvl_n
                               & ~cfg_ff.fourWire;
            serialDataOutOe <= (serState_ff == SER_DRIVE) & ~selLvl_n
                               & cfg_ff.fourWire;
        end
    end

    // ****************************************************************
    // events, alarm and apb registers
    // ****************************************************************
    logic [EV_W-1:0] intStatus_ff;
    logic [EV_W-1:0] intEnable_ff;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] intClear;
    logic            apbAccess;
    logic            apbCommit;

    assign apbAccess = psel & penable;
    assign apbCommit = apbAccess & pready & pwrite;
    assign events    = {cfgWrite, syncHit, collide};
    assign intClear  = (apbCommit && paddr == OFS_INT_CLEAR) ? pwdata[EV_W-1:0] : '0;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            intStatus_ff <= INT_RESET;
        else
            intStatus_ff <= (intStatus_ff & ~intClear) | events; // set beats clear
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm <= 1'b0;
            irq   <= 1'b0;
        end
        else
        begin
            alarm <= |intStatus_ff;
            irq   <= |(intStatus_ff & intEnable_ff);
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff      <= CTRL_RESET;
            intEnable_ff <= INT_RESET;
        end
        else if (apbCommit)
        begin
            if (paddr == OFS_CTRL)
                ctrl_ff <= pwdata;
            if (paddr == OFS_INT_ENABLE)
                intEnable_ff <= pwdata[EV_W-1:0];
        end
    end

    // one wait state: data and ready are both registered
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= apbAccess & ~pready;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (apbAccess && !pready)
            begin
                unique case (paddr)
                    OFS_CTRL:       prdata <= ctrl_ff;
                    OFS_STATE:
                    begin
                        prdata[ST_GATE_BIT]               <= gateLvl;
                        prdata[ST_SLEEP_BIT]              <= sleepLvl;
                        prdata[ST_FOUR_BIT]               <= cfg_ff.fourWire;
                        prdata[ST_REV_BIT]                <= cfg_ff.reverseBus;
                        prdata[ST_WPTR_LSB +: PTR_W]      <= wrPtr_ff;
                        prdata[ST_RPTR_LSB +: PTR_W]      <= rdPtr_ff;
                    end
                    OFS_INT_STATUS: prdata[EV_W-1:0] <= intStatus_ff;
                    OFS_INT_CLEAR:  prdata <= '0;
                    OFS_INT_ENABLE: prdata[EV_W-1:0] <= intEnable_ff;
                    OFS_SAMPLE:
                    begin
                        prdata[SAMPLE_W-1:0]              <= corePair.chA;
                        prdata[SMP_CHB_LSB +: SAMPLE_W]   <= corePair.chB;
                    end
                    default:        pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_gate_zero_out: assert property (!gateOk |=> corePair == '0 && !coreStrobe)
        else $error("datapath not zero while gate low");
    a_gate_ignore_bus: assert property (!gateOk && linkFall |=> $stable(wrPtr_ff) || $past(syncHit))
        else $error("word accepted while gate low");
    a_chan_a_rise: assert property (linkRise && gateOk |=> chALatch_ff == $past(busWord))
        else $error("rising word not taken as channel A");
    a_pair_write: assert property (pairWrite |=> wrPtr_ff == $past(wrPtr_ff) + 1'b1)
        else $error("pair not written on falling edge");
    a_bus_order: assert property (!cfg_ff.reverseBus |-> busWord == busData)
        else $error("bus order wrong without reversal");
    a_sync_ptrs: assert property (syncHit |=> wrPtr_ff == '0 && rdPtr_ff == $past(syncOfs))
        else $error("pointers not aligned by sync");
    a_sdio_input_only: assert property (cfg_ff.fourWire |=> !serialDataIoOe)
        else $error("serial data pin driven in 4-wire mode");
    a_sdo_released: assert property (!cfg_ff.fourWire |=> !serialDataOutOe)
        else $error("serial out driven in 3-wire mode");
    a_cfg_reset: assert property (!serialReset_n |-> cfg_ff == CFG_RESET)
        else $error("config not cleared by serial reset");
    a_sleep_follow: assert property (sleepLvl |=> sleepActive && corePair == '0
                                     && !coreStrobe)
        else $error("sleep not entered");
    a_alarm_event: assert property (collide |=> ##1 alarm)
        else $error("alarm not raised on collision");

    c_pair_written: cover property (pairWrite ##[1:20] rdTick_ff && gateOk && !collide);
    c_serial_read: cover property (serialDataIoOe ##[1:200] serState_ff == SER_DONE);
    c_fifo_sync: cover property (syncHit);
    c_collision: cover property (collide ##2 irq);
endmodule
